// *** srgs_sequencer.sv ***
`timescale 1ns/10ps
`include "srgs_regs.svh"
module srgs_sequencer #(
  parameter logic [`SRGS_WAKE_W-1:0] WAKE_REC_CYC = `SRGS_WAKE_REC_DEF
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_clk_en,
  input  wire srgs_pkg::srgs_cmp_s    i_cmp,
  input  wire logic [`SRGS_TMR_W-1:0] i_min_on_cyc,
  input  wire logic [`SRGS_TMR_W-1:0] i_min_off_cyc,
  input  wire logic                   i_disable,
  output logic                        o_gate_drive_output,
  output logic                        o_off_blank_active
);

  // clamp a configured length to its floor
  function automatic logic [`SRGS_TMR_W-1:0] clamp_len(input logic [`SRGS_TMR_W-1:0] cfg,
                                                       input logic [`SRGS_TMR_W-1:0] floor_v);
    clamp_len = (cfg < floor_v) ? floor_v : cfg;
  endfunction

  localparam logic [`SRGS_TMR_W-1:0] ON_FLOOR  = `SRGS_TMR_W'(`SRGS_MIN_ON_CYC);
  localparam logic [`SRGS_TMR_W-1:0] OFF_FLOOR = `SRGS_TMR_W'(`SRGS_MIN_OFF_CYC);

  // two-flop synchronisers; meta stage feeds only the second stage
  srgs_pkg::srgs_cmp_s meta_q, meta_d, sync_q, sync_d;
  always_comb begin
    meta_d = i_cmp;
    sync_d = meta_q;
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (i_clk_en) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  logic [`SRGS_TMR_W-1:0] on_len, off_len;
  assign on_len  = clamp_len(i_min_on_cyc, ON_FLOOR);
  assign off_len = clamp_len(i_min_off_cyc, OFF_FLOOR);

  srgs_pkg::srgs_state_e  st_q, st_d;
  logic [`SRGS_TMR_W-1:0] on_cnt_q, on_cnt_d;
  logic [`SRGS_TMR_W-1:0] off_cnt_q, off_cnt_d;
  logic                   off_run_q, off_run_d;
  logic                   off_done_q, off_done_d;
  logic                   above_q, above_d;
  logic [`SRGS_WAKE_W-1:0] wake_q, wake_d;
  logic                   drv_q, drv_d;
  logic                   off_expire;

  assign off_expire = off_run_q && (off_cnt_q == off_len - `SRGS_TMR_ONE);

  // off blanking timer: starts on rise above reset threshold, clears below it
  always_comb begin
    off_cnt_d  = off_cnt_q;
    off_run_d  = off_run_q;
    off_done_d = off_done_q;
    above_d    = sync_q.off_reset;
    if (st_q == srgs_pkg::SRGS_WAKE || st_q == srgs_pkg::SRGS_ON) begin
      off_cnt_d  = `SRGS_TMR_ZERO;
      off_run_d  = 1'b0;
      off_done_d = 1'b0;
      above_d    = 1'b0; // a level already high counts as a fresh start
    end else if (!sync_q.off_reset) begin
      off_cnt_d = `SRGS_TMR_ZERO;
      off_run_d = 1'b0;
    end else if (!above_q) begin
      off_cnt_d = `SRGS_TMR_ZERO;
      off_run_d = 1'b1;
    end else if (off_expire) begin
      off_run_d  = 1'b0;
      off_done_d = 1'b1;
    end else if (off_run_q) begin
      off_cnt_d = off_cnt_q + `SRGS_TMR_ONE;
    end
  end

  // main sequence and on blanking
  always_comb begin
    st_d     = st_q;
    on_cnt_d = on_cnt_q;
    wake_d   = wake_q;
    drv_d    = drv_q;
    case (st_q)
      srgs_pkg::SRGS_WAKE: begin
        drv_d = 1'b0;
        if (wake_q == WAKE_REC_CYC) begin
          st_d = srgs_pkg::SRGS_SYNC;
        end else begin
          wake_d = wake_q + `SRGS_WAKE_ONE;
        end
      end
      srgs_pkg::SRGS_SYNC: begin
        // self synchronisation: only a full uninterrupted off period releases
        if (off_done_q) begin
          st_d = srgs_pkg::SRGS_OFF;
        end
      end
      srgs_pkg::SRGS_OFF: begin
        if (sync_q.turn_on && off_done_q) begin
          st_d     = srgs_pkg::SRGS_ON;
          drv_d    = 1'b1;
          on_cnt_d = `SRGS_TMR_ZERO;
        end
      end
      srgs_pkg::SRGS_ON: begin
        if (on_cnt_q < on_len - `SRGS_TMR_ONE) begin
          on_cnt_d = on_cnt_q + `SRGS_TMR_ONE;
        end else if (sync_q.turn_off) begin
          st_d  = srgs_pkg::SRGS_OFF;
          drv_d = 1'b0;
        end
      end
      default: begin
        st_d  = srgs_pkg::SRGS_WAKE;
        drv_d = 1'b0;
      end
    endcase
    if (i_disable) begin
      st_d   = srgs_pkg::SRGS_WAKE;
      wake_d = `SRGS_WAKE_ZERO;
      drv_d  = 1'b0;
    end
  end

  // reset clears everything and demands a full off period before driving
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q       <= srgs_pkg::SRGS_WAKE;
      on_cnt_q   <= `SRGS_TMR_ZERO;
      off_cnt_q  <= `SRGS_TMR_ZERO;
      off_run_q  <= 1'b0;
      off_done_q <= 1'b0;
      above_q    <= 1'b0;
      wake_q     <= `SRGS_WAKE_ZERO;
      drv_q      <= 1'b0;
    end else if (i_clk_en) begin
      st_q       <= st_d;
      on_cnt_q   <= on_cnt_d;
      off_cnt_q  <= off_cnt_d;
      off_run_q  <= off_run_d;
      off_done_q <= off_done_d;
      above_q    <= above_d;
      wake_q     <= wake_d;
      drv_q      <= drv_d;
    end
  end

  assign o_gate_drive_output = drv_q;
  assign o_off_blank_active  = off_run_q;

  // drive rises only from an idle state with a full off period done
  property p_on_needs_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(drv_q) |-> $past(off_done_q) && $past(sync_q.turn_on);
  endproperty
  a_on_needs_off: assert property (p_on_needs_off) else $error("drive rose without off period");

  property p_on_hold;
    @(posedge i_clk) disable iff (i_sys_rst || i_disable)
      $rose(drv_q) |-> drv_q [*7];
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("drive dropped inside on blanking");

  property p_turn_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      st_q == srgs_pkg::SRGS_ON && i_clk_en && sync_q.turn_off && on_cnt_q >= on_len - `SRGS_TMR_ONE
      |=> !drv_q;
  endproperty
  a_turn_off: assert property (p_turn_off) else $error("drive not removed on turn-off");

  property p_clear_below;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_clk_en && !sync_q.off_reset |=> !off_run_q;
  endproperty
  a_clear_below: assert property (p_clear_below) else $error("off timer not cleared");

  property p_start_rise;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_clk_en && sync_q.off_reset && !above_q && (st_q == srgs_pkg::SRGS_OFF || st_q == srgs_pkg::SRGS_SYNC)
      |=> off_run_q && off_cnt_q == `SRGS_TMR_ZERO;
  endproperty
  a_start_rise: assert property (p_start_rise) else $error("off timer did not start");

  property p_sync_quiet;
    @(posedge i_clk) disable iff (i_sys_rst)
      st_q == srgs_pkg::SRGS_SYNC || st_q == srgs_pkg::SRGS_WAKE |-> !drv_q;
  endproperty
  a_sync_quiet: assert property (p_sync_quiet) else $error("drive during start-up wait");

  property p_disable;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_clk_en && i_disable |=> !drv_q && st_q == srgs_pkg::SRGS_WAKE;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not stop drive");

  property p_reset_state;
    @(posedge i_clk) $past(i_sys_rst) |-> !drv_q && !off_run_q && !off_done_q;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset left state set");

  // reset edges zero the chain, so they are kept out of the latency window
  property p_sync_delay;
    @(posedge i_clk) disable iff (i_sys_rst)
      $past(i_clk_en) && $past(i_clk_en, 2) && !$past(i_sys_rst) && !$past(i_sys_rst, 2) |-> sync_q == $past(i_cmp, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("comparator sync latency wrong");

  // gate drive exists only in the on state
  property p_drive_in_on;
    @(posedge i_clk) disable iff (i_sys_rst)
      drv_q |-> st_q == srgs_pkg::SRGS_ON;
  endproperty
  a_drive_in_on: assert property (p_drive_in_on) else $error("drive outside on state");

  // the floor holds even when the setting is shorter
  property p_on_floor;
    @(posedge i_clk) disable iff (i_sys_rst || i_disable)
      st_q == srgs_pkg::SRGS_ON && i_clk_en && on_cnt_q < ON_FLOOR - `SRGS_TMR_ONE |=> drv_q;
  endproperty
  a_on_floor: assert property (p_on_floor) else $error("drive dropped below on floor");

  // the configured length keeps the drive up, turn-off or not
  property p_on_cfg;
    @(posedge i_clk) disable iff (i_sys_rst || i_disable)
      st_q == srgs_pkg::SRGS_ON && i_clk_en && on_cnt_q < on_len - `SRGS_TMR_ONE |=> drv_q;
  endproperty
  a_on_cfg: assert property (p_on_cfg) else $error("drive dropped before configured on time");

  // done flag only ever comes from a timer expiry
  property p_expire_done;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(off_done_q) |-> $past(off_expire);
  endproperty
  a_expire_done: assert property (p_expire_done) else $error("off period done without expiry");

  // each pulse uses up its off period
  property p_on_clears_done;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(drv_q) && i_clk_en |=> !off_done_q;
  endproperty
  a_on_clears_done: assert property (p_on_clears_done) else $error("off period reused");

  // recovery wait wipes any earlier timer progress
  property p_wake_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      st_q == srgs_pkg::SRGS_WAKE && i_clk_en |=> !off_run_q && !off_done_q;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("timer kept through wake");

  // uninterrupted high level advances the count by one
  property p_count_step;
    @(posedge i_clk) disable iff (i_sys_rst)
      off_run_q && i_clk_en && sync_q.off_reset && above_q && !off_expire
      && (st_q == srgs_pkg::SRGS_OFF || st_q == srgs_pkg::SRGS_SYNC)
      |=> off_cnt_q == $past(off_cnt_q) + `SRGS_TMR_ONE;
  endproperty
  a_count_step: assert property (p_count_step) else $error("off timer skipped a count");

  // ringing below the threshold throws the running count away
  property p_ring_restart;
    @(posedge i_clk) disable iff (i_sys_rst)
      off_run_q && i_clk_en && !sync_q.off_reset && (st_q == srgs_pkg::SRGS_OFF || st_q == srgs_pkg::SRGS_SYNC)
      |=> off_cnt_q == `SRGS_TMR_ZERO && !off_run_q;
  endproperty
  a_ring_restart: assert property (p_ring_restart) else $error("ringing did not restart timer");

  // sync wait is left only through a complete off period or a disable
  property p_sync_wait;
    @(posedge i_clk) disable iff (i_sys_rst)
      st_q == srgs_pkg::SRGS_SYNC && !off_done_q && i_clk_en && !i_disable |=> st_q == srgs_pkg::SRGS_SYNC;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("sync wait left early");

  // bias recovery runs its full count
  property p_wake_count;
    @(posedge i_clk) disable iff (i_sys_rst)
      st_q == srgs_pkg::SRGS_WAKE && i_clk_en && !i_disable && wake_q != WAKE_REC_CYC
      |=> st_q == srgs_pkg::SRGS_WAKE;
  endproperty
  a_wake_count: assert property (p_wake_count) else $error("recovery wait cut short");

  // reset restarts the whole start-up sequence
  property p_reset_cycle;
    @(posedge i_clk)
      $past(i_sys_rst) |-> st_q == srgs_pkg::SRGS_WAKE && wake_q == `SRGS_WAKE_ZERO;
  endproperty
  a_reset_cycle: assert property (p_reset_cycle) else $error("reset skipped start-up wait");
endmodule

// *** srgs_regs.svh ***
`ifndef SRGS_REGS_SVH
`define SRGS_REGS_SVH
// timing figures in ns, clock period in ns
`define SRGS_CLK_PERIOD_NS   8
`define SRGS_MIN_ON_NS       55
`define SRGS_MIN_OFF_NS      245
// clamps: least times round up to whole cycles
`define SRGS_MIN_ON_CYC      ((`SRGS_MIN_ON_NS + `SRGS_CLK_PERIOD_NS - 1) / `SRGS_CLK_PERIOD_NS)
`define SRGS_MIN_OFF_CYC     ((`SRGS_MIN_OFF_NS + `SRGS_CLK_PERIOD_NS - 1) / `SRGS_CLK_PERIOD_NS)
`define SRGS_TMR_W           16
`define SRGS_TMR_ZERO        16'h0000
`define SRGS_TMR_ONE         16'h0001
`define SRGS_WAKE_REC_DEF    12'h064
`define SRGS_WAKE_W          12
`define SRGS_WAKE_ZERO       12'h000
`define SRGS_WAKE_ONE        12'h001
`endif

// *** srgs_pkg.sv ***
package srgs_pkg;
  // comparator outputs, all asynchronous at the pins
  typedef struct packed {
    logic turn_on;     // sense below turn_on_threshold
    logic turn_off;    // sense above turn_off_threshold
    logic off_reset;   // sense above off_timer_reset_threshold
  } srgs_cmp_s;

  typedef enum logic [1:0] {
    SRGS_WAKE,
    SRGS_SYNC,
    SRGS_OFF,
    SRGS_ON
  } srgs_state_e;
endpackage

// *** srgs_sense_model.sv ***
`timescale 1ns/10ps
// current-sense comparators on the rectifier drain, sense in tenths of mV
module srgs_sense_model #(
  parameter int TH_ON  = -800,
  parameter int TH_OFF = -5,
  parameter int TH_RST = 5000
) (
  input  int                 i_sense,
  output srgs_pkg::srgs_cmp_s o_cmp
);
  // plain levels, changing whenever sense moves, not aligned to the clock
  always_comb begin
    o_cmp.turn_on   = i_sense < TH_ON;
    o_cmp.turn_off  = i_sense > TH_OFF;
    o_cmp.off_reset = i_sense > TH_RST;
  end
endmodule

// *** srgs_sequencer_bench.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module srgs_sequencer_bench;
  localparam int HI = 20000;  // reverse voltage, all comparators high but turn_on
  localparam int LO = -10000; // body diode conducting
  localparam int MID = 100;   // just past turn-off, below reset threshold
  logic                i_clk = 1'b0;
  logic                i_sys_rst = 1'b1;
  logic                i_disable = 1'b0;
  logic                i_clk_en = 1'b1;
  logic [15:0]         i_min_on_cyc = 16'h0010;
  logic [15:0]         i_min_off_cyc = 16'h0020;
  logic                o_gate_drive_output;
  logic                o_off_blank_active;
  srgs_pkg::srgs_cmp_s cmp;
  int                  sense = MID;
  int                  num_errors = 0;
  int                  check_count = 0;
  srgs_sense_model sm_u (.i_sense(sense), .o_cmp(cmp));
  srgs_sequencer #(.WAKE_REC_CYC(12'h002)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_cmp(cmp), .i_min_on_cyc(i_min_on_cyc), .i_min_off_cyc(i_min_off_cyc), .i_disable(i_disable),
    .o_gate_drive_output(o_gate_drive_output), .o_off_blank_active(o_off_blank_active));
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // configured length, raised to its floor when set too short
  function automatic int eff(input logic [15:0] v, input int fl);
    return (int'(v) < fl) ? fl : int'(v);
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one rectifier cycle: ringing, full off period, turn-on, early turn-off
  task automatic pulse(input logic [15:0] on_c, input logic [15:0] off_c);
    int n;
    int eoff;
    eoff = eff(off_c, 31);
    i_min_on_cyc <= on_c;
    i_min_off_cyc <= off_c;
    sense <= HI;
    cyc(eoff - 4);
    `CHK(o_off_blank_active, 1'b1)
    sense <= LO;
    cyc(5);
    `CHK(o_off_blank_active, 1'b0)
    `CHK(o_gate_drive_output, 1'b0)
    sense <= HI;
    cyc(eoff + 6);
    sense <= LO;
    n = 0;
    while (o_gate_drive_output !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    `CHK(o_gate_drive_output, 1'b1)
    sense <= MID; // turn-off condition at once, must be blanked
    n = 0;
    while (o_gate_drive_output === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    `CHK(n >= eff(on_c, 7) && n <= eff(on_c, 7) + 4, 1'b1)
    $display("pulse on %0d off %0d done", on_c, off_c);
  endtask
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  initial begin
    void'($urandom(76057));
    cyc(2);
    i_sys_rst <= 1'b0;
    `CHK(o_gate_drive_output, 1'b0)
    sense <= LO; // startup with diode already on: no drive before sync
    cyc(12);
    `CHK(o_gate_drive_output, 1'b0)
    pulse(16'h0000, 16'h0000);
    pulse(16'h0007, 16'h001f);
    for (int i = 0; i < 6; i++) pulse(16'($urandom_range(60)), 16'($urandom_range(70)));
    sense <= HI; // full off period first, so the disable cuts a real pulse
    cyc(80);
    sense <= LO;
    cyc(6);
    `CHK(o_gate_drive_output, 1'b1)
    i_disable <= 1'b1; // forced off while conducting
    sense <= HI; // already high when the wake comes
    cyc(3);
    `CHK(o_gate_drive_output, 1'b0)
    `CHK(o_off_blank_active, 1'b0)
    i_disable <= 1'b0;
    cyc(6);
    `CHK(o_off_blank_active, 1'b1)
    `CHK(o_gate_drive_output, 1'b0)
    i_clk_en <= 1'b0; // frozen: the fall below threshold goes unseen
    sense <= LO;
    cyc(5);
    `CHK(o_off_blank_active, 1'b1)
    i_clk_en <= 1'b1;
    cyc(4);
    `CHK(o_off_blank_active, 1'b0)
    sense <= HI;
    cyc(5);
    `CHK(o_off_blank_active, 1'b1)
    i_sys_rst <= 1'b1;
    cyc(2);
    `CHK(o_off_blank_active, 1'b0)
    i_sys_rst <= 1'b0;
    pulse(16'h0009, 16'h0028);
    $display("tests done");
    conclude();
  end
endmodule
